// ==== rtl/stepper_profile_command_port.v ====
// command acceptance and trapezoid step-rate profile of a stepper axis
// assumes: command words held steady by the controller while in use,
// command bits and index input arrive asynchronously on pins
//
// Summary of operation
// - multiplier is 600 over the divisor
// - top rate is multiplier times 8191
// - motion commands start at base speed
// - ramp up, ramp down, then stop stepping
// - final home search at constant base speed
// - peak rate is running word times multiplier
// - short moves decelerate early, triangular profile
// - accel word sets longest ramp-up milliseconds
// - ramps no longer than (run-base)/0.3 ms
// - decel word sets ramp-down; zero copies accel
// - index adds fixed further steps same direction
// - after index use indexed decel time
// - window opens and closes at step counts
// - index input honoured only inside window
// - commands act on rising edge, jog excepted
// - start a detected command within 4 ms
// - jog runs while bit high, stops after
// - power-up error set; clear-errors comes first
// - while moving without errors only stop commands accepted
// - highest bit number wins in one scan
// - errors refuse all but clear-errors
`timescale 1ns/1ps
`default_nettype none
`include "stepper_defs.vh"

module stepper_profile_command_port #(
    parameter MS_TICK_CYCLES = `MS_TICK_CYCLES,
    parameter DIV_W          = 40
) (
    input  wire        clock,
    input  wire        sys_rst,
    input  wire [15:0] command_bits,
    input  wire        index_in,
    input  wire [15:0] velocity_divisor,
    input  wire [15:0] base_speed_word,
    input  wire [15:0] running_speed_word,
    input  wire [15:0] accel_time_ms,
    input  wire [15:0] decel_time_ms,
    input  wire [31:0] indexed_extra_steps,
    input  wire [15:0] indexed_decel_time_ms,
    input  wire [31:0] index_window_open_steps,
    input  wire [31:0] index_window_close_steps,
    input  wire [31:0] move_distance,
    input  wire        move_dir,
    input  wire        fault_event,
    input  wire        stop_now,
    input  wire        home_fine_search,
    output wire        step_pulse,
    output reg         step_dir,
    output reg         moving_flag,
    output reg         accel_flag,
    output reg         decel_flag,
    output reg         powerup_error_flag,
    output reg         fault_flag,
    output reg         cmd_accept,
    output reg  [3:0]  cmd_index,
    output reg         index_seen
);
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_CALC = 3'b010;
    localparam [2:0] ST_MOVE = 3'b100;
    localparam [31:0] TICK_LAST = MS_TICK_CYCLES - 1;

    // highest set bit of the edge vector, with a hit flag on top
    function [4:0] top_bit;
        input [15:0] v;
        integer i;
        begin
            top_bit = 5'h00;
            for (i = 0; i < 16; i = i + 1) begin
                if (v[i]) begin
                    top_bit = {1'b1, i[3:0]};
                end
            end
        end
    endfunction

    // three-stage synchronisers, bit 16 is the index input
    wire [16:0] pin_in = {index_in, command_bits};
    reg  [16:0] sync1_reg;
    reg  [16:0] sync2_reg;
    reg  [16:0] sync3_reg;
    reg  [16:0] stable_reg;
    reg  [16:0] prev_reg;

    genvar g;
    generate
        for (g = 0; g < 17; g = g + 1) begin : pin_sync
            always @(posedge clock) begin
                if (sys_rst) begin
                    sync1_reg[g]  <= 1'b0;
                    sync2_reg[g]  <= 1'b0;
                    sync3_reg[g]  <= 1'b0;
                    stable_reg[g] <= 1'b0;
                    prev_reg[g]   <= 1'b0;
                end else begin
                    sync1_reg[g] <= pin_in[g];
                    sync2_reg[g] <= sync1_reg[g];
                    sync3_reg[g] <= sync2_reg[g];
                    if (sync2_reg[g] == sync3_reg[g]) begin
                        stable_reg[g] <= sync3_reg[g];
                    end
                    prev_reg[g] <= stable_reg[g];
                end
            end
        end
    endgenerate

    wire [16:0] rise    = stable_reg & ~prev_reg;
    wire [4:0]  top     = top_bit(rise[15:0]);
    wire [3:0]  sel     = top[3:0];
    wire        err_any = powerup_error_flag | fault_flag;
    reg         legal;

    always @* begin
        legal = 1'b0;
        if (top[4]) begin
            if (err_any) begin
                legal = (sel == `CLEAR_ERRORS_CMD);
            end else if (moving_flag) begin
                legal = (sel == `DECEL_AND_STOP_CMD) ||
                        (sel == `IMMEDIATE_STOP_CMD);
            end else begin
                legal = 1'b1;
            end
        end
    end

    wire is_motion = (sel >= `CMD_HOME_UP) && (sel <= `CMD_MOTION_LAST);
    wire is_jog    = (sel == `JOG_UP_CMD) || (sel == `JOG_DOWN_CMD);
    wire is_home   = (sel == `CMD_HOME_UP) || (sel == `CMD_HOME_DOWN);
    wire dir_down  = (sel == `JOG_DOWN_CMD) || (sel == `CMD_HOME_DOWN);

    // millisecond time base
    reg  [31:0] ms_cnt_reg;
    wire        ms_tick = (ms_cnt_reg == TICK_LAST);

    always @(posedge clock) begin
        if (sys_rst || ms_tick) begin
            ms_cnt_reg <= 32'h0;
        end else begin
            ms_cnt_reg <= ms_cnt_reg + 32'h1;
        end
    end

    // velocity words clamped to 13 bits so the top rate is 8191 words
    wire [12:0] base_c = (base_speed_word > {3'h0, `VEL_WORD_MAX}) ?
                         `VEL_WORD_MAX : base_speed_word[12:0];
    wire [12:0] run_c  = (running_speed_word > {3'h0, `VEL_WORD_MAX}) ?
                         `VEL_WORD_MAX : running_speed_word[12:0];
    // a running word at or below base gives a flat profile at base
    wire [12:0] span   = (run_c > base_c) ? run_c - base_c : 13'h0000;
    wire [31:0] base_q = {3'h0, base_c, 16'h0000};
    wire [31:0] run_q  = {3'h0, (run_c > base_c) ? run_c : base_c, 16'h0000};

    wire [15:0] decel_eff = (decel_time_ms == 16'h0000) ?
                            accel_time_ms : decel_time_ms;
    reg         idx_mode_reg;
    reg         seen_reg;
    wire [15:0] decel_sel = (seen_reg && indexed_decel_time_ms != 16'h0000) ?
                            indexed_decel_time_ms : decel_eff;

    // slope calculation: accel slope, decel slope, then their ratio
    reg  [1:0]       stage_reg;
    reg              div_run_reg;
    reg              div_start;
    reg  [DIV_W-1:0] div_num;
    reg  [DIV_W-1:0] div_den;
    wire             div_done;
    wire [DIV_W-1:0] div_quot;
    reg  [31:0]      slope_a_reg;
    reg  [31:0]      slope_d_reg;
    reg  [31:0]      ratio_reg;
    wire [31:0]      q_lo    = div_quot[31:0];
    wire [31:0]      q_slope = (q_lo < `MIN_SLOPE) ? `MIN_SLOPE : q_lo;

    always @* begin
        div_num = {DIV_W{1'b0}};
        div_den = {{(DIV_W-1){1'b0}}, 1'b1};
        case (stage_reg)
            2'd0: begin
                div_num = {11'h000, span, 16'h0000};
                if (accel_time_ms != 16'h0000) begin
                    div_den = {24'h000000, accel_time_ms};
                end
            end
            2'd1: begin
                div_num = {11'h000, span, 16'h0000};
                if (decel_sel != 16'h0000) begin
                    div_den = {24'h000000, decel_sel};
                end
            end
            default: begin
                div_num = {slope_a_reg, 8'h00};
                div_den = {8'h00, slope_d_reg};
            end
        endcase
    end

    seq_divider #(
        .W (DIV_W)
    ) u_div (
        .clock   (clock),
        .sys_rst (sys_rst),
        .start   (div_start),
        .num     (div_num),
        .den     (div_den),
        .done    (div_done),
        .quot    (div_quot)
    );

    // motion state
    reg  [2:0]  state_reg;
    reg  [31:0] vel_q_reg;
    reg  [31:0] remain_reg;
    reg  [31:0] steps_reg;
    reg  [39:0] need_reg;
    reg         bounded_reg;
    reg         jog_reg;
    reg  [3:0]  jog_bit_reg;
    reg         stop_req_reg;
    wire        step_raw;

    wire [32:0] vel_up   = {1'b0, vel_q_reg} + {1'b0, slope_a_reg};
    wire [32:0] vel_dn   = {1'b0, vel_q_reg} - {1'b0, slope_d_reg};
    wire        jog_off  = jog_reg && !stable_reg[jog_bit_reg];
    wire        near_end = bounded_reg &&
                           (remain_reg <= need_reg[39:`RATIO_FRAC]);
    wire        decel_go = stop_req_reg || jog_off || near_end;
    wire        win_open = (steps_reg >= index_window_open_steps) &&
                           (steps_reg <  index_window_close_steps);
    wire        idx_hit  = idx_mode_reg && !seen_reg && win_open &&
                           rise[16];
    wire        at_base  = (vel_q_reg <= base_q);
    wire        step_en  = (state_reg == ST_MOVE) &&
                           !(bounded_reg && remain_reg == 32'h0);

    step_rate_gen u_rate (
        .clock      (clock),
        .sys_rst    (sys_rst),
        .enable     (step_en),
        .vel_word   (vel_q_reg[28:16]),
        .divisor    (velocity_divisor),
        .step_pulse (step_raw)
    );

    assign step_pulse = step_raw;

    always @(posedge clock) begin
        if (sys_rst) begin
            state_reg          <= ST_IDLE;
            powerup_error_flag <= `PWRUP_ERR_RESET;
            fault_flag         <= 1'b0;
            cmd_accept         <= 1'b0;
            cmd_index          <= 4'h0;
            moving_flag        <= 1'b0;
            accel_flag         <= 1'b0;
            decel_flag         <= 1'b0;
            step_dir           <= 1'b0;
            index_seen         <= 1'b0;
            stage_reg          <= 2'd0;
            div_run_reg        <= 1'b0;
            div_start          <= 1'b0;
            slope_a_reg        <= `MIN_SLOPE;
            slope_d_reg        <= `MIN_SLOPE;
            ratio_reg          <= 32'h0;
            vel_q_reg          <= 32'h0;
            remain_reg         <= 32'h0;
            steps_reg          <= 32'h0;
            need_reg           <= 40'h0;
            bounded_reg        <= 1'b0;
            jog_reg            <= 1'b0;
            jog_bit_reg        <= 4'h0;
            stop_req_reg       <= 1'b0;
            idx_mode_reg       <= 1'b0;
            seen_reg           <= 1'b0;
        end else begin
            cmd_accept <= legal;
            div_start  <= 1'b0;
            if (legal) begin
                cmd_index <= sel;
            end
            // a fault in the clearing cycle survives the clear
            if (legal && sel == `CLEAR_ERRORS_CMD) begin
                powerup_error_flag <= 1'b0;
                fault_flag         <= fault_event;
            end else if (fault_event) begin
                fault_flag <= 1'b1;
            end

            // divider sequencer, also rerun mid-move after an index
            if (div_done && div_run_reg) begin
                case (stage_reg)
                    2'd0: begin
                        slope_a_reg <= q_slope;
                        stage_reg   <= 2'd1;
                        div_start   <= 1'b1;
                    end
                    2'd1: begin
                        slope_d_reg <= q_slope;
                        stage_reg   <= 2'd2;
                        div_start   <= 1'b1;
                    end
                    default: begin
                        ratio_reg   <= q_lo;
                        div_run_reg <= 1'b0;
                    end
                endcase
            end

            case (state_reg)
                ST_IDLE: begin
                    if (legal && is_motion) begin
                        // divider takes about 130 clocks, far inside 4 ms
                        state_reg    <= ST_CALC;
                        moving_flag  <= 1'b1;
                        step_dir     <= (is_jog || is_home) ? dir_down : move_dir;
                        bounded_reg  <= !(is_jog || is_home);
                        jog_reg      <= is_jog;
                        jog_bit_reg  <= sel;
                        idx_mode_reg <= (sel == `INDEXED_MOVE_CMD);
                        seen_reg     <= 1'b0;
                        index_seen   <= 1'b0;
                        stop_req_reg <= 1'b0;
                        remain_reg   <= move_distance;
                        steps_reg    <= 32'h0;
                        need_reg     <= 40'h0;
                        stage_reg    <= 2'd0;
                        div_run_reg  <= 1'b1;
                        div_start    <= 1'b1;
                    end
                end
                ST_CALC: begin
                    if (div_done && stage_reg == 2'd2) begin
                        state_reg  <= ST_MOVE;
                        vel_q_reg  <= base_q;
                        accel_flag <= 1'b1;
                    end
                end
                ST_MOVE: begin
                    if (step_raw) begin
                        steps_reg <= steps_reg + 32'h1;
                        if (bounded_reg) begin
                            remain_reg <= remain_reg - 32'h1;
                        end
                        if (accel_flag) begin
                            need_reg <= need_reg + {8'h00, ratio_reg};
                        end
                    end
                    if (idx_hit) begin
                        seen_reg    <= 1'b1;
                        index_seen  <= 1'b1;
                        bounded_reg <= 1'b1;
                        remain_reg  <= indexed_extra_steps;
                        stage_reg   <= 2'd1;
                        div_run_reg <= 1'b1;
                        div_start   <= 1'b1;
                    end
                    if (home_fine_search) begin
                        vel_q_reg  <= base_q;
                        accel_flag <= 1'b0;
                        decel_flag <= 1'b0;
                    end else if (decel_go) begin
                        accel_flag <= 1'b0;
                        decel_flag <= !at_base;
                        if (ms_tick) begin
                            vel_q_reg <= (vel_dn[32] || vel_dn[31:0] < base_q) ?
                                         base_q : vel_dn[31:0];
                        end
                    end else if (vel_q_reg < run_q) begin
                        accel_flag <= 1'b1;
                        if (ms_tick) begin
                            vel_q_reg <= (vel_up > {1'b0, run_q}) ?
                                         run_q : vel_up[31:0];
                        end
                    end else begin
                        accel_flag <= 1'b0;
                        decel_flag <= 1'b0;
                    end
                    if (legal && sel == `DECEL_AND_STOP_CMD) begin
                        stop_req_reg <= 1'b1;
                    end
                    if ((bounded_reg && remain_reg == 32'h0) ||
                        (!bounded_reg && decel_go && at_base)) begin
                        state_reg   <= ST_IDLE;
                        moving_flag <= 1'b0;
                        accel_flag  <= 1'b0;
                        decel_flag  <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase

            // sudden stops override everything else, also during calc
            if ((legal && sel == `IMMEDIATE_STOP_CMD) || stop_now) begin
                state_reg   <= ST_IDLE;
                moving_flag <= 1'b0;
                accel_flag  <= 1'b0;
                decel_flag  <= 1'b0;
                div_run_reg <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// ==== inc/stepper_defs.vh ====
// constants shared by the stepper profile and command logic
// assumes: included by bare name from the command port and step rate rtl files, no code here
`ifndef STEPPER_DEFS_VH
`define STEPPER_DEFS_VH

`define CLK_HZ          50000000
`define TIME_BASE_MS    1
`define MS_TICK_CYCLES  (`CLK_HZ / 1000 * `TIME_BASE_MS)
`define CMD_START_MS    4

// multiplier numerator and largest velocity word
`define VEL_MUL_NUM     10'h258
`define VEL_WORD_MAX    13'h1fff
`define VEL_FRAC_BITS   16
// 0.3 velocity words per ms in 16-bit fraction
`define MIN_SLOPE       32'h00004ccd
`define RATIO_FRAC      8

// command bit positions (bit n-1 carries command n)
`define CMD_HOME_UP     4'h3
`define CMD_HOME_DOWN   4'h4
`define JOG_UP_CMD      4'h5
`define JOG_DOWN_CMD    4'h6
`define CMD_MOTION_LAST 4'ha
`define INDEXED_MOVE_CMD   4'ha
`define CLEAR_ERRORS_CMD   4'hd
`define DECEL_AND_STOP_CMD 4'he
`define IMMEDIATE_STOP_CMD 4'hf

`define PWRUP_ERR_RESET 1'b1

`endif

// ==== rtl/seq_divider.v ====
// restoring divider, one quotient bit per clock
// assumes: start is a one-cycle pulse, operands steady until done
`timescale 1ns/1ps
`default_nettype none

module seq_divider #(
    parameter W = 40
) (
    input  wire         clock,
    input  wire         sys_rst,
    input  wire         start,
    input  wire [W-1:0] num,
    input  wire [W-1:0] den,
    output reg          done,
    output reg  [W-1:0] quot
);
    localparam integer CNT_INT  = W;
    localparam [6:0]   CNT_INIT = CNT_INT[6:0];

    reg  [W-1:0] rem_reg;
    reg  [6:0]   cnt_reg;
    reg          busy_reg;
    wire [W:0]   shifted = {rem_reg, quot[W-1]};
    wire [W:0]   diff    = shifted - {1'b0, den};

    always @(posedge clock) begin
        if (sys_rst) begin
            rem_reg  <= {W{1'b0}};
            quot     <= {W{1'b0}};
            cnt_reg  <= 7'h00;
            busy_reg <= 1'b0;
            done     <= 1'b0;
        end else if (start) begin
            rem_reg  <= {W{1'b0}};
            quot     <= num;
            cnt_reg  <= CNT_INIT;
            busy_reg <= 1'b1;
            done     <= 1'b0;
        end else if (busy_reg) begin
            if (!diff[W]) begin
                rem_reg <= diff[W-1:0];
            end else begin
                rem_reg <= shifted[W-1:0];
            end
            quot    <= {quot[W-2:0], ~diff[W]};
            cnt_reg <= cnt_reg - 7'h01;
            if (cnt_reg == 7'h01) begin
                busy_reg <= 1'b0;
                done     <= 1'b1;
            end
        end else begin
            done <= 1'b0;
        end
    end
endmodule

`default_nettype wire

// ==== rtl/step_rate_gen.v ====
// step pulse generator: rate = vel_word * 600 / divisor pulses per second
// assumes: one clock at CLK_HZ, divisor zero means no stepping
`timescale 1ns/1ps
`default_nettype none
`include "stepper_defs.vh"

module step_rate_gen #(
    parameter CLK_HZ = `CLK_HZ
) (
    input  wire        clock,
    input  wire        sys_rst,
    input  wire        enable,
    input  wire [12:0] vel_word,
    input  wire [15:0] divisor,
    output reg         step_pulse
);
    localparam integer HZ_INT = CLK_HZ;
    localparam [25:0]  HZ     = HZ_INT[25:0];

    // exact ratio: add word*600 per clock, wrap at divisor*clock rate
    wire [41:0] thr = divisor * HZ;
    wire [22:0] inc = vel_word * `VEL_MUL_NUM;
    reg  [42:0] acc_reg;
    wire [42:0] sum = acc_reg + {20'h00000, inc};

    always @(posedge clock) begin
        if (sys_rst || !enable || divisor == 16'h0000) begin
            acc_reg    <= 43'h0;
            step_pulse <= 1'b0;
        end else if (sum >= {1'b0, thr}) begin
            acc_reg    <= sum - {1'b0, thr};
            step_pulse <= 1'b1;
        end else begin
            acc_reg    <= sum;
            step_pulse <= 1'b0;
        end
    end
endmodule

`default_nettype wire

// ==== verification/spcp_chk.sv ====
// assertions on the pins of the stepper command port
// assumes: bound to the top module, one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module spcp_chk (
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic [15:0] command_bits,
    input wire logic        fault_event,
    input wire logic        step_pulse,
    input wire logic        moving_flag,
    input wire logic        accel_flag,
    input wire logic        decel_flag,
    input wire logic        powerup_error_flag,
    input wire logic        fault_flag,
    input wire logic        cmd_accept,
    input wire logic [3:0]  cmd_index
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // pin history, so an accept can be traced back to its edge
    logic [15:0] pin_q [1:8];
    always_ff @(posedge clock) begin
        pin_q[1] <= command_bits;
        for (int i = 2; i <= 8; i++)
            pin_q[i] <= pin_q[i-1];
    end
    chk_accept_on_rise:
    assert property (cmd_accept |-> (pin_q[4][cmd_index] || pin_q[5][cmd_index] || pin_q[6][cmd_index])
        && !(pin_q[6][cmd_index] && pin_q[7][cmd_index] && pin_q[8][cmd_index])) else $error("accept without rise");
    chk_accept_one_cycle:
    assert property (cmd_accept |=> !cmd_accept) else $error("accept longer than one cycle");
    chk_clear_latency:
    assert property ($rose(command_bits[13]) && command_bits[15:14] == 2'h0 && !moving_flag && !fault_event
        |-> ##[4:6] cmd_accept) else $error("clear not started in time");
    chk_reset_state:
    assert property ($fell(sys_rst) |-> powerup_error_flag && !moving_flag && !fault_flag) else $error("bad reset state");
    chk_error_refuse:
    assert property (cmd_accept && $past(powerup_error_flag || fault_flag) |-> cmd_index == 4'hd)
        else $error("command taken with error set");
    chk_error_sticky:
    assert property ($fell(powerup_error_flag) || $fell(fault_flag) |-> cmd_accept && cmd_index == 4'hd)
        else $error("error dropped without clear");
    chk_moving_refuse:
    assert property (cmd_accept && $past(moving_flag) |-> cmd_index >= 4'he) else $error("command taken while moving");
    chk_stop_fast:
    assert property (cmd_accept && cmd_index == 4'hf |-> ##[0:8] !moving_flag) else $error("stop too slow");
    chk_step_moving:
    assert property (step_pulse |-> moving_flag || $past(moving_flag)) else $error("step while idle");
    chk_ramp_excl:
    assert property (!(accel_flag && decel_flag)) else $error("accel and decel together");
    chk_jog_release:
    assert property ($fell(command_bits[5]) && moving_flag && cmd_index == 4'h5
        |-> ##[1:8] (decel_flag || !moving_flag)) else $error("jog not ramping down");
    cov_clear: cover property (cmd_accept && cmd_index == 4'hd);
    cov_jog: cover property (cmd_accept && cmd_index == 4'h5);
    cov_stop: cover property (cmd_accept && cmd_index == 4'hf);
endmodule
bind stepper_profile_command_port spcp_chk u_chk (.clock, .sys_rst, .command_bits, .fault_event, .step_pulse,
    .moving_flag, .accel_flag, .decel_flag, .powerup_error_flag, .fault_flag, .cmd_accept, .cmd_index);
`default_nettype wire

// ==== verification/plc_model.sv ====
// controller side: raises and drops command bits
// assumes: GAP is 4 ms in clock cycles at the bench time base
`timescale 1ns/1ps
`default_nettype none
module plc_model #(
    parameter int GAP = 200
) (
    input wire logic        clock,
    output var logic [15:0] command_bits
);
    initial command_bits = 16'h0000;
    task automatic raise(input logic [15:0] m);
        @(posedge clock);
        command_bits <= m;
    endtask
    // every bit low a full 4 ms before the next rise
    task automatic drop();
        @(posedge clock);
        command_bits <= 16'h0000;
        repeat (GAP) @(posedge clock);
    endtask
    task automatic issue(input logic [15:0] m, input int hold);
        raise(m);
        repeat (hold) @(posedge clock);
        drop();
    endtask
endmodule
`default_nettype wire

// ==== verification/stepper_profile_command_port_tb_top.sv ====
// bench for the stepper command port
// assumes: sim time base of 50 clocks per ms, real 50 MHz step timing
`timescale 1ns/1ps
`default_nettype none
module stepper_profile_command_port_tb_top;
    localparam int MS = 50;
    localparam int BASE_GAP = 50000000 * 20 / (1000 * 600);
    localparam int RUN_GAP = 50000000 * 20 / (8000 * 600);
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic        index_in = 1'b0;
    logic        fault_event = 1'b0;
    logic        stop_now = 1'b0;
    logic        home_fine_search = 1'b0;
    logic        move_dir = 1'b0;
    logic [15:0] velocity_divisor = 16'h0014;
    logic [15:0] base_speed_word = 16'h03e8;
    logic [15:0] running_speed_word = 16'h1f40; // above base
    logic [15:0] accel_time_ms = 16'h000a;
    logic [15:0] decel_time_ms = 16'h0000;
    logic [15:0] indexed_decel_time_ms = 16'h0000;
    logic [31:0] indexed_extra_steps = 32'h0000_0005;
    logic [31:0] index_window_open_steps = 32'h0000_0002;
    logic [31:0] index_window_close_steps = 32'h0000_0028;
    logic [31:0] move_distance = 32'h0000_0040;
    wire  [15:0] command_bits;
    wire         step_pulse, step_dir, moving_flag, accel_flag, decel_flag;
    wire         powerup_error_flag, fault_flag, cmd_accept, index_seen;
    wire  [3:0]  cmd_index;
    int          n_fail = 0, checks = 0, n_acc = 0, n_step = 0, cyc = 0, t_step = 0, gap = 0, n0 = 0;
    logic [3:0]  last_idx = 4'h0;
    always #10 clock = ~clock;
    plc_model #(.GAP(4 * MS)) u_plc (.clock, .command_bits);
    stepper_profile_command_port #(.MS_TICK_CYCLES(MS)) u_dut (.clock, .sys_rst, .command_bits, .index_in,
        .velocity_divisor, .base_speed_word, .running_speed_word, .accel_time_ms, .decel_time_ms,
        .indexed_extra_steps, .indexed_decel_time_ms, .index_window_open_steps, .index_window_close_steps,
        .move_distance, .move_dir, .fault_event, .stop_now, .home_fine_search, .step_pulse, .step_dir,
        .moving_flag, .accel_flag, .decel_flag, .powerup_error_flag, .fault_flag, .cmd_accept, .cmd_index,
        .index_seen);
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cmd_accept === 1'b1) begin
            n_acc <= n_acc + 1;
            last_idx <= cmd_index;
        end
        if (step_pulse === 1'b1) begin
            n_step <= n_step + 1;
            gap <= cyc - t_step;
            t_step <= cyc;
        end
    end
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clock);
        n_fail++;
        finish_test();
    end
    initial begin
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        chk(powerup_error_flag, 1);
        u_plc.issue(16'h0020, 20);
        chk(n_acc, 0);
        u_plc.issue(16'h2080, 300);
        chk({n_acc, last_idx, powerup_error_flag}, {32'h1, 4'hd, 1'b0});
        home_fine_search <= 1'b1;
        u_plc.raise(16'h0020);
        repeat (6000) @(posedge clock);
        chk({moving_flag, step_dir, last_idx}, {1'b1, 1'b0, 4'h5});
        chk(gap >= BASE_GAP && gap <= BASE_GAP + 1, 1);
        home_fine_search <= 1'b0;
        repeat (3000) @(posedge clock);
        chk(gap >= RUN_GAP && gap <= RUN_GAP + 1, 1);
        u_plc.raise(16'h2020);
        repeat (20) @(posedge clock);
        chk(n_acc, 2);
        u_plc.drop();
        repeat (1500) @(posedge clock);
        chk(moving_flag, 0);
        for (int k = 14; k <= 15; k++) begin
            u_plc.raise(16'h0020);
            repeat (2000) @(posedge clock);
            u_plc.raise(16'h0020 | (16'h1 << k));
            repeat (20) @(posedge clock);
            chk(last_idx, k);
            u_plc.drop();
            repeat (1500) @(posedge clock);
            chk(moving_flag === 1'b0 && cyc - t_step > 1000, 1);
        end
        fault_event <= 1'b1;
        @(posedge clock);
        fault_event <= 1'b0;
        u_plc.issue(16'h0020, 20);
        chk({fault_flag, last_idx}, {1'b1, 4'hf});
        u_plc.issue(16'h2000, 20);
        chk(fault_flag, 0);
        move_dir <= 1'b1;
        u_plc.raise(16'h0400);
        repeat (3000) @(posedge clock);
        index_in <= 1'b1;
        n0 = n_step;
        repeat (5000) @(posedge clock);
        chk({moving_flag, index_seen, step_dir}, {1'b0, 1'b1, 1'b1});
        chk((n_step - n0) inside {5, 6}, 1);
        finish_test();
    end
endmodule
`default_nettype wire
